// [bench/dbp_dac_model.sv]
/* Byte-load parallel DAC model: input and DAC registers.
   Assumes the host pins are wired straight in. */
`timescale 1ns/1ps
`default_nettype none
module dbp_dac_model (
  input  wire logic              cs_n,
  input  wire logic              wr_n,
  input  wire logic              load_output_n,
  input  wire logic              async_zero_n,
  input  wire logic              upper_byte_select,
  input  wire dbp_pkg::dbp_bus_t bus_data,
  output dbp_pkg::dbp_code_t     dac_code,
  output logic                   dac_gain,
  output logic                   dac_buf
);
  import dbp_pkg::*;
  dbp_code_t in_code;
  logic      in_gain, in_buf, fresh;
  // =====
  // Registers
  task automatic zero_all();
    {in_code, in_gain, in_buf, fresh, dac_code, dac_gain, dac_buf} = '0;
  endtask : zero_all
  // whole 12-bit code moves at once
  task automatic transfer();
    {dac_code, dac_gain, dac_buf} = {in_code, in_gain, in_buf};
    fresh = 1'b0;
  endtask : transfer
  // zero at power-up, sleep never touches
  initial zero_all();
  always @(negedge async_zero_n) zero_all();
  always @(posedge wr_n) begin
    if (async_zero_n && !cs_n) begin
      if (upper_byte_select)
        {in_buf, in_gain, in_code[11:8]} = {bus_data[7:6], bus_data[3:0]};
      else
        in_code[7:0] = bus_data;
      fresh = 1'b1;
      if (!load_output_n) transfer();
    end
  end
  always @(negedge load_output_n) if (async_zero_n && fresh) transfer();
endmodule : dbp_dac_model
`default_nettype wire

// [bench/dbp_host_properties.sv]
/* Pin timing checker for dbp_host.
   Assumes a bind from the bench top file. */
`timescale 1ns/1ps
`default_nettype none
module dbp_host_properties (
  input wire logic              clk_sys,
  input wire logic              rst_b,
  input wire logic              sync_mode,
  input wire logic              clear_req,
  input wire logic              cs_n,
  input wire logic              wr_n,
  input wire logic              load_output_n,
  input wire logic              async_zero_n,
  input wire logic              upper_byte_select,
  input wire dbp_pkg::dbp_bus_t bus_data
);
  import dbp_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // =====
  // Pin relations
  store_under_cs_a: assert property ($rose(wr_n) |-> !cs_n)
    else $error("store edge without select");
  pulse_width_a: assert property ($fell(wr_n) && async_zero_n |=> !wr_n ##1 wr_n)
    else $error("store pulse width wrong");
  bus_steady_a: assert property (!wr_n |-> $stable(bus_data))
    else $error("bus moved during store");
  sync_overlap_a: assert property ($rose(wr_n) && upper_byte_select && sync_mode
    |-> !load_output_n)
    else $error("no load at capture in sync mode");
  async_quiet_a: assert property (!sync_mode && !wr_n |-> load_output_n)
    else $error("load during async write");
  async_load_a: assert property ($fell(load_output_n) && !sync_mode |-> wr_n && cs_n)
    else $error("async load while selected");
  low_first_a: assert property ($rose(wr_n) && !upper_byte_select |-> load_output_n)
    else $error("load with half code");
  load_after_high_a: assert property ($fell(load_output_n) |-> upper_byte_select && wr_n)
    else $error("load before high byte");
  clear_pin_a: assert property (clear_req |=> !async_zero_n)
    else $error("clear not driven");
endmodule : dbp_host_properties
`default_nettype wire

// [bench/dbp_host_tb.sv]
/* Self-checking bench for dbp_host with a DAC model.
   Assumes package, model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module dbp_host_tb;
  import dbp_pkg::*;
  logic      clk_sys, rst_b, start, gain, buf_sel, sync_mode, clear_req, sleep_req;
  logic      busy, done, cs_n, wr_n, load_output_n, async_zero_n, upper_byte_select;
  logic      sleep_n, dac_gain, dac_buf;
  dbp_code_t code, dac_code;
  dbp_bus_t  bus_data;
  int        mismatches, checked, n;
  // Row: code, gain, buffer, sync, cycles to done
  logic [18:0] rows [4] = '{{12'hA5C, 3'h5, 4'h9}, {12'h3F0, 3'h2, 4'hB},
                            {12'hFFF, 3'h7, 4'h9}, {12'h001, 3'h0, 4'hB}};
  dbp_host dut_u (.clk_sys, .rst_b, .start, .code, .gain, .buf_sel, .sync_mode,
    .clear_req, .sleep_req, .busy, .done, .cs_n, .wr_n, .load_output_n,
    .async_zero_n, .upper_byte_select, .sleep_n, .bus_data);
  dbp_dac_model dac_u (.cs_n, .wr_n, .load_output_n, .async_zero_n,
    .upper_byte_select, .bus_data, .dac_code, .dac_gain, .dac_buf);
  // =====
  // Tasks
  task automatic chk(input string nm, input logic [13:0] exp, input logic [13:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic run(input logic [18:0] r);
    {code, gain, buf_sel, sync_mode} = r[18:4];
    start = 1'b1;
    @(posedge clk_sys) #5 start = 1'b0;
    chk("busy", 14'h1, 14'(busy));
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clk_sys) #5 n++;
    end
    chk("latency", 14'(r[3:0]), 14'(n));
    chk("dac", r[18:5], {dac_code, dac_gain, dac_buf});
  endtask : run
  // =====
  // Sequence
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Whole run is under a hundred cycles
  initial begin
    #2000000 mismatches++;
    summarize();
  end
  initial begin
    {rst_b, start, code, gain, buf_sel, sync_mode, clear_req, sleep_req} = '0;
    repeat (12) @(posedge clk_sys);
    #5 chk("idle pins", 14'h3E, 14'({cs_n, wr_n, load_output_n, async_zero_n, sleep_n, upper_byte_select}));
    chk("reset dac", 14'h0, {dac_code, dac_gain, dac_buf});
    rst_b = 1'b1;
    @(posedge clk_sys) #5;
    foreach (rows[i]) run(rows[i]);
    sleep_req = 1'b1;
    repeat (2) @(posedge clk_sys) #5;
    chk("sleep pin", 14'h0, 14'(sleep_n));
    chk("kept dac", 14'h4, {dac_code, dac_gain, dac_buf});
    {sleep_req, start} = 2'h1;
    @(posedge clk_sys) #5 start = 1'b0;
    repeat (5) @(posedge clk_sys) #5;
    clear_req = 1'b1;
    repeat (2) @(posedge clk_sys) #5;
    chk("clear dac", 14'h0, {dac_code, dac_gain, dac_buf});
    clear_req = 1'b0;
    repeat (3) @(posedge clk_sys) #5;
    chk("after clear", 14'h3, 14'({busy, cs_n, sleep_n}));
    run(rows[0]);
    summarize();
  end
endmodule : dbp_host_tb
bind dbp_host dbp_host_properties chk_u (.clk_sys, .rst_b, .sync_mode, .clear_req,
  .cs_n, .wr_n, .load_output_n, .async_zero_n, .upper_byte_select, .bus_data);
`default_nettype wire

// [hdl/dbp_host.sv]
/*
 Host controller that writes a byte-load 12-bit parallel DAC: low byte, high
 byte carrying gain and buffer bits, with a load strobe pulse at high-byte capture (sync mode) or after it (async mode).
 Assumes the DAC pins are wired straight to the outputs; one 10 MHz clock.
*/
// Functional notes
// - Data captured on store-strobe rise while chip select low.
// - Synchronous mode: load low during write updates after capture.
// - Asynchronous mode: write alone leaves output; load strobe updates.
// - Host writes both bytes before asserting load strobe.
`timescale 1ns/1ps
`default_nettype none
`include "dbp_map.svh"

module dbp_host (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          start,
  input  wire dbp_pkg::dbp_code_t code,
  input  wire logic          gain,
  input  wire logic          buf_sel,
  input  wire logic          sync_mode,
  input  wire logic          clear_req,
  input  wire logic          sleep_req,
  output logic               busy,
  output logic               done,
  output logic               cs_n,
  output logic               wr_n,
  output logic               load_output_n,
  output logic               async_zero_n,
  output logic               upper_byte_select,
  output logic               sleep_n,
  output dbp_pkg::dbp_bus_t  bus_data
);
  import dbp_pkg::*;

  // ==========================================================
  // Write sequencer
  dbp_state_t                state;
  logic [`DBP_CNT_W-1:0]     cnt;
  logic                      hi_phase;
  dbp_code_t                 code_q;
  logic                      gain_q;
  logic                      buf_q;
  logic                      sync_q;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      code_q <= '0;
      gain_q <= 1'b0;
      buf_q  <= 1'b0;
      sync_q <= 1'b0;
    end else if (state == DBP_IDLE && start && !clear_req) begin
      code_q <= code;
      gain_q <= gain;
      buf_q  <= buf_sel;
      sync_q <= sync_mode;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state    <= DBP_IDLE;
      cnt      <= '0;
      hi_phase <= 1'b0;
    end else if (clear_req) begin
      state    <= DBP_IDLE;
      cnt      <= '0;
      hi_phase <= 1'b0;
    end else begin
      case (state)
        DBP_IDLE: begin
          hi_phase <= 1'b0;
          cnt      <= '0;
          if (start) begin
            state <= DBP_SETUP;
          end
        end
        DBP_SETUP: begin
          if (cnt == `DBP_CNT_W'(`DBP_SETUP_CYC - 1)) begin
            cnt   <= '0;
            state <= DBP_PULSE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        DBP_PULSE: begin
          if (cnt == `DBP_CNT_W'(`DBP_PULSE_CYC - 1)) begin
            cnt   <= '0;
            state <= DBP_HOLD;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        DBP_HOLD: begin
          if (cnt == `DBP_CNT_W'(`DBP_HOLD_CYC - 1)) begin
            cnt <= '0;
            if (!hi_phase) begin
              hi_phase <= 1'b1;
              state    <= DBP_SETUP;
            end else if (sync_q) begin
              state <= DBP_DONE;
            end else begin
              state <= DBP_LOAD;
            end
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        DBP_LOAD: begin
          if (cnt == `DBP_CNT_W'(`DBP_PULSE_CYC - 1)) begin
            cnt   <= '0;
            state <= DBP_DONE;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        DBP_DONE: state <= DBP_IDLE;
        default:  state <= DBP_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Pin drivers, all registered
  // select held through whole write
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cs_n <= 1'b1;
    end else begin
      // Stays low one more cycle after a strobe cut by a clear
      cs_n <= !(state == DBP_SETUP || state == DBP_PULSE || state == DBP_HOLD || !wr_n);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_n <= 1'b1;
    end else begin
      wr_n <= !(state == DBP_PULSE);
    end
  end

  // byte layout with gain and buffer bits
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upper_byte_select <= 1'b0;
      bus_data          <= '0;
    end else begin
      upper_byte_select <= hi_phase;
      if (hi_phase) begin
        bus_data                <= '0;
        bus_data[`DBP_HI_W-1:0] <= code_q[`DBP_CODE_W-1:`DBP_BUS_W];
        bus_data[`DBP_GAIN_BIT] <= gain_q;
        bus_data[`DBP_BUF_BIT]  <= buf_q;
      end else begin
        bus_data <= code_q[`DBP_BUS_W-1:0];
      end
    end
  end

  // sync mode pulses load at high-byte capture
  // async mode pulses load after both bytes
  // never low before high byte lands
  // Earlier fall would copy a half-written code out
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      load_output_n <= 1'b1;
    end else begin
      load_output_n <= !((state == DBP_LOAD) ||
                         (sync_q && hi_phase && (state == DBP_HOLD)));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      async_zero_n <= 1'b1;
    end else begin
      async_zero_n <= !clear_req;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sleep_n <= 1'b1;
    end else begin
      sleep_n <= !sleep_req;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      busy <= (state != DBP_IDLE) || (start && !clear_req);
      done <= (state == DBP_DONE);
    end
  end

endmodule : dbp_host
`default_nettype wire

// [hdl/dbp_map.svh]
/*
 Timing counts and pin-field layout for the parallel DAC host controller.
 Assumes a 10 MHz system clock; included by the package and the controller.
*/
`ifndef DBP_MAP_SVH
`define DBP_MAP_SVH

`define DBP_CLK_NS        100
`define DBP_SETUP_NS      100
`define DBP_PULSE_NS      200
`define DBP_HOLD_NS       100
`define DBP_SETUP_CYC     ((`DBP_SETUP_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_PULSE_CYC     ((`DBP_PULSE_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_HOLD_CYC      ((`DBP_HOLD_NS + `DBP_CLK_NS - 1) / `DBP_CLK_NS)
`define DBP_CODE_W        12
`define DBP_BUS_W         8
`define DBP_HI_W          4
`define DBP_GAIN_BIT      6
`define DBP_BUF_BIT       7
`define DBP_CNT_W         4

`endif

// [hdl/dbp_pkg.sv]
/*
 Types for the parallel DAC host controller.
 Assumes dbp_map.svh sits on the include path.
*/
`default_nettype none
`include "dbp_map.svh"

package dbp_pkg;
  typedef logic [`DBP_CODE_W-1:0] dbp_code_t;
  typedef logic [`DBP_BUS_W-1:0]  dbp_bus_t;
  typedef enum logic [5:0] {
    DBP_IDLE  = 6'b000001,
    DBP_SETUP = 6'b000010,
    DBP_PULSE = 6'b000100,
    DBP_HOLD  = 6'b001000,
    DBP_LOAD  = 6'b010000,
    DBP_DONE  = 6'b100000
  } dbp_state_t;
endpackage : dbp_pkg
`default_nettype wire
